//--- hdl/threshold_learning_defines.svh
// constants for the vibration threshold learning block
`ifndef THRESHOLD_LEARNING_DEFINES_SVH
`define THRESHOLD_LEARNING_DEFINES_SVH
`define CLK_FREQ_HZ 100000000
`define HOLD_TIME_S 2
`define HOLD_CYCLES (`HOLD_TIME_S * `CLK_FREQ_HZ)
`define LEARN_TIME_S 30
`define LEARN_CYCLES ($unsigned(`LEARN_TIME_S) * $unsigned(`CLK_FREQ_HZ))
`define TOGGLE_TIME_MS 1000
`define TOGGLE_CYCLES (`TOGGLE_TIME_MS * (`CLK_FREQ_HZ / 1000))
`define AVG_SHIFT 8
`define THR_WIDTH 16
`define THR_MIN 16'h0019
`define THR_MAX 16'h01f4
`define THR_RESET 16'h0064
`endif

//--- hdl/threshold_learning_pkg.sv
// types for the vibration threshold learning block
package threshold_learning_pkg;
   typedef enum logic [2:0] {
      st_idle, st_hold, st_sample, st_store, st_wait_nv, st_settle
   } learn_state_type;
endpackage : threshold_learning_pkg

//--- hdl/threshold_store_if.sv
// carrier between learning sequencer and the threshold store
`timescale 1ns/1ps
interface threshold_store_if #(parameter int WIDTH = 16);
   logic wr_en;
   logic [WIDTH-1:0] wr_data;
   logic [WIDTH-1:0] rd_data;
   logic busy;
   modport master (output wr_en, output wr_data, input rd_data, input busy);
   modport store (input wr_en, input wr_data, output rd_data, output busy);
endinterface : threshold_store_if

//--- hdl/threshold_store.sv
// retained threshold store with a write time per changed step
`timescale 1ns/1ps
`include "threshold_learning_defines.svh"
module threshold_store #(
   parameter int WIDTH = 16,
   parameter int STEP_CYCLES = 4
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   threshold_store_if.store port_s
);
   typedef struct packed {
      logic [WIDTH-1:0] value;
      logic [WIDTH-1:0] target;
      logic [15:0] step;
      logic busy;
   } store_state_type;
   store_state_type state_r;
   store_state_type state_nxt;
   always_comb begin
      state_nxt = state_r;
      if (state_r.busy) begin
         if (state_r.step >= 16'(STEP_CYCLES - 1)) begin
            state_nxt.step = '0;
            if (state_r.value < state_r.target) begin
               state_nxt.value = state_r.value + 1'b1;
            end else if (state_r.value > state_r.target) begin
               state_nxt.value = state_r.value - 1'b1;
            end else begin
               state_nxt.busy = 1'b0;
            end
         end else begin
            state_nxt.step = state_r.step + 16'h0001;
         end
      end else if (port_s.wr_en) begin
         state_nxt.target = port_s.wr_data;
         state_nxt.busy = 1'b1;
         state_nxt.step = '0;
      end
   end
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= '{value: WIDTH'(`THR_RESET), target: WIDTH'(`THR_RESET),
                      step: 16'h0000, busy: 1'b0};
      end else begin
         state_r <= state_nxt;
      end
   end
   assign port_s.rd_data = state_r.value;
   assign port_s.busy = state_r.busy;
   a_store_busy_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      state_r.busy && state_r.value != state_r.target |=> state_r.busy)
      else $error("store dropped busy before reaching target");
endmodule : threshold_store

//--- hdl/threshold_learning.sv
// magnet started vibration threshold learning sequencer
// Notes on behaviour
// - magnet ignored unless learning option enabled
// - start after magnet held two seconds
// - new threshold is twice average amplitude
// - learned threshold saved in retained storage
// - relay toggles repeatedly while learning runs
// - sequence lasts at least thirty seconds
// - threshold limited to quarter to five
`timescale 1ns/1ps
`include "threshold_learning_defines.svh"
module threshold_learning #(
   parameter int HOLD_CYCLES = `HOLD_CYCLES,
   parameter int unsigned LEARN_CYCLES = `LEARN_CYCLES,
   parameter int TOGGLE_CYCLES = `TOGGLE_CYCLES,
   parameter int AVG_SHIFT = `AVG_SHIFT,
   parameter int STEP_CYCLES = 4,
   parameter int WIDTH = `THR_WIDTH
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic auto_threshold_learning_i,
   input wire logic magnet_i,
   input wire logic sample_valid_i,
   input wire logic [WIDTH-1:0] amplitude_i,
   input wire logic relay_normal_i,
   output logic relay_o,
   output logic learning_o,
   output logic done_o,
   output logic [WIDTH-1:0] threshold_o
);
   localparam int SAMPLES = 1 << AVG_SHIFT;
   typedef struct packed {
      threshold_learning_pkg::learn_state_type st;
      logic [31:0] timer;
      logic [31:0] toggle;
      logic [WIDTH+AVG_SHIFT-1:0] sum;
      logic [AVG_SHIFT:0] count;
      logic [WIDTH-1:0] learned;
      logic relay;
      logic done;
   } learn_type;
   learn_type state_r;
   learn_type state_nxt;
   threshold_store_if #(.WIDTH(WIDTH)) store_bus ();
   threshold_store #(.WIDTH(WIDTH), .STEP_CYCLES(STEP_CYCLES)) u_store (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .port_s(store_bus)
   );
   function automatic logic [WIDTH-1:0] clamp_thr(
      input logic [WIDTH:0] v);
      if (v < (WIDTH+1)'(`THR_MIN)) begin
         return WIDTH'(`THR_MIN);
      end else if (v > (WIDTH+1)'(`THR_MAX)) begin
         return WIDTH'(`THR_MAX);
      end
      return v[WIDTH-1:0];
   endfunction : clamp_thr
   logic learn_active;
   assign learn_active = state_r.st != threshold_learning_pkg::st_idle &&
      state_r.st != threshold_learning_pkg::st_hold;
   always_comb begin
      state_nxt = state_r;
      state_nxt.done = 1'b0;
      if (learn_active) begin
         state_nxt.timer = state_r.timer + 32'h1;
         if (state_r.toggle >= 32'(TOGGLE_CYCLES - 1)) begin
            state_nxt.toggle = '0;
            state_nxt.relay = ~state_r.relay;
         end else begin
            state_nxt.toggle = state_r.toggle + 32'h1;
         end
      end
      store_bus.wr_en = 1'b0;
      store_bus.wr_data = state_r.learned;
      unique case (state_r.st)
         threshold_learning_pkg::st_idle: begin
            state_nxt.relay = relay_normal_i;
            state_nxt.timer = '0;
            if (auto_threshold_learning_i && magnet_i) begin
               state_nxt.st = threshold_learning_pkg::st_hold;
            end
         end
         threshold_learning_pkg::st_hold: begin
            if (!magnet_i || !auto_threshold_learning_i) begin
               state_nxt.st = threshold_learning_pkg::st_idle;
            end else if (state_r.timer >= 32'(HOLD_CYCLES - 1)) begin
               state_nxt.st = threshold_learning_pkg::st_sample;
               state_nxt.timer = '0;
               state_nxt.toggle = '0;
               state_nxt.sum = '0;
               state_nxt.count = '0;
            end else begin
               state_nxt.timer = state_r.timer + 32'h1;
            end
         end
         threshold_learning_pkg::st_sample: begin
            if (sample_valid_i) begin
               state_nxt.sum = state_r.sum + (WIDTH+AVG_SHIFT)'(amplitude_i);
               state_nxt.count = state_r.count + 1'b1;
            end
            if (state_r.count == (AVG_SHIFT+1)'(SAMPLES)) begin
               state_nxt.learned = clamp_thr({state_r.sum[WIDTH+AVG_SHIFT-1:
                  AVG_SHIFT], 1'b0});
               state_nxt.sum = state_r.sum;
               state_nxt.count = state_r.count;
               state_nxt.st = threshold_learning_pkg::st_store;
            end
         end
         threshold_learning_pkg::st_store: begin
            store_bus.wr_en = !store_bus.busy;
            if (!store_bus.busy) begin
               state_nxt.st = threshold_learning_pkg::st_wait_nv;
            end
         end
         threshold_learning_pkg::st_wait_nv: begin
            if (!store_bus.busy && store_bus.rd_data == state_r.learned) begin
               state_nxt.st = threshold_learning_pkg::st_settle;
            end
         end
         threshold_learning_pkg::st_settle: begin
            if (state_r.timer >= 32'(LEARN_CYCLES - 1)) begin
               state_nxt.st = threshold_learning_pkg::st_idle;
               state_nxt.relay = relay_normal_i;
               state_nxt.done = 1'b1;
               state_nxt.timer = '0;
            end
         end
         default: begin
            state_nxt.st = threshold_learning_pkg::st_idle;
         end
      endcase
   end
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= '{st: threshold_learning_pkg::st_idle, timer: 32'h0,
                      toggle: 32'h0, sum: '0, count: '0, learned: '0,
                      relay: 1'b0, done: 1'b0};
      end else begin
         state_r <= state_nxt;
      end
   end
   assign relay_o = state_r.relay;
   assign learning_o = learn_active;
   assign done_o = state_r.done;
   assign threshold_o = store_bus.rd_data;

   a_gate_enable: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      state_r.st == threshold_learning_pkg::st_idle &&
      !auto_threshold_learning_i |=>
      state_r.st == threshold_learning_pkg::st_idle)
      else $error("left idle with learning disabled");
   a_hold_abort: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      state_r.st == threshold_learning_pkg::st_hold && !magnet_i |=>
      state_r.st == threshold_learning_pkg::st_idle)
      else $error("hold not aborted on magnet release");
   a_twice_avg: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      state_r.st == threshold_learning_pkg::st_sample &&
      state_nxt.st == threshold_learning_pkg::st_store |=>
      state_r.learned == clamp_thr({$past(state_r.sum[WIDTH+AVG_SHIFT-1:
      AVG_SHIFT]), 1'b0}))
      else $error("learned threshold not twice the average");
   a_thr_range: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      state_r.st == threshold_learning_pkg::st_store |->
      state_r.learned >= WIDTH'(`THR_MIN) &&
      state_r.learned <= WIDTH'(`THR_MAX))
      else $error("learned threshold out of range");
   a_store_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      state_r.st == threshold_learning_pkg::st_store && !store_bus.busy |->
      store_bus.wr_en ##1 store_bus.busy)
      else $error("store write not issued");
   a_relay_flip: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      learn_active && state_r.toggle == 32'(TOGGLE_CYCLES - 1) &&
      state_nxt.st != threshold_learning_pkg::st_idle |=>
      relay_o != $past(relay_o))
      else $error("relay did not toggle");
   a_relay_normal: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      done_o |-> relay_o == $past(relay_normal_i))
      else $error("relay not normal after learning");
   a_min_length: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $rose(done_o) |-> $past(state_r.timer) >= 32'(LEARN_CYCLES - 1))
      else $error("learning ended early");
   c_hold_start: cover property (@(posedge clock_i) disable iff (!rst_n_i)
      state_r.st == threshold_learning_pkg::st_hold ##1
      state_r.st == threshold_learning_pkg::st_sample);
   c_hold_abort: cover property (@(posedge clock_i) disable iff (!rst_n_i)
      state_r.st == threshold_learning_pkg::st_hold ##1
      state_r.st == threshold_learning_pkg::st_idle);
   c_done: cover property (@(posedge clock_i) disable iff (!rst_n_i) done_o);
endmodule : threshold_learning

//--- verif/vib_source_model.sv
// far side model: vibration path giving alternating amplitude samples
`timescale 1ns/1ps
module vib_source_model (
   input wire logic clock_i,
   input wire logic [15:0] level_a_i,
   input wire logic [15:0] level_b_i,
   output logic sample_valid_o,
   output logic [15:0] amplitude_o
);
   logic [2:0] tick_r;
   logic phase_r;
   initial begin
      tick_r = 3'h0;
      phase_r = 1'b0;
      sample_valid_o = 1'b0;
      amplitude_o = 16'h0000;
   end
   // one sample every eight cycles, data scrambled between samples
   always @(negedge clock_i) begin
      tick_r <= tick_r + 3'h1;
      sample_valid_o <= (tick_r == 3'h7);
      if (tick_r == 3'h7) begin
         amplitude_o <= phase_r ? level_b_i : level_a_i;
         phase_r <= ~phase_r;
      end else begin
         amplitude_o <= ~amplitude_o;
      end
   end
endmodule : vib_source_model

//--- verif/threshold_learning_tb.sv
// self-checking bench for the threshold learning sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module threshold_learning_tb;
   localparam int HOLD = 20;
   localparam int LEARN = 2000;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic enable = 1'b0;
   logic magnet = 1'b0;
   logic relay_normal = 1'b0;
   logic [15:0] lvl_a = 16'h0000;
   logic [15:0] lvl_b = 16'h0000;
   logic sample_valid, relay_o, learning_o, done_o;
   logic relay_prev = 1'b0;
   logic [15:0] amplitude, threshold_o, want;
   logic [15:0] exp_q[$];
   int n_errors = 0;
   int total_checks = 0;
   int run_cycles = 0;
   int toggles = 0;
   initial begin
      forever #5 clock_i = ~clock_i;
   end
   vib_source_model partner (.clock_i(clock_i), .level_a_i(lvl_a),
      .level_b_i(lvl_b), .sample_valid_o(sample_valid),
      .amplitude_o(amplitude));
   threshold_learning #(.HOLD_CYCLES(HOLD), .LEARN_CYCLES(LEARN),
      .TOGGLE_CYCLES(50), .AVG_SHIFT(2), .STEP_CYCLES(1)) uut (
      .clock_i(clock_i), .rst_n_i(rst_n_i),
      .auto_threshold_learning_i(enable), .magnet_i(magnet),
      .sample_valid_i(sample_valid), .amplitude_i(amplitude),
      .relay_normal_i(relay_normal), .relay_o(relay_o),
      .learning_o(learning_o), .done_o(done_o), .threshold_o(threshold_o));
   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude
   function automatic logic [15:0] learned(input logic [15:0] a, b);
      logic [17:0] v;
      v = (({2'b00, a} + {2'b00, b}) >> 1) << 1;
      if (v < 18'h00019) return 16'h0019;
      if (v > 18'h001f4) return 16'h01f4;
      return v[15:0];
   endfunction : learned
   // watcher: length, toggles and stored value at each end pulse
   always @(posedge clock_i) begin
      #1;
      if (learning_o === 1'b1 && relay_o !== relay_prev) toggles++;
      if (learning_o === 1'b1) run_cycles++;
      relay_prev = relay_o;
      if (done_o === 1'b1) begin
         want = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hffff;
         `CHK(threshold_o, want)
         `CHK(run_cycles > LEARN - 4 && run_cycles < LEARN + 4, 1'b1)
         `CHK(toggles >= 38 && toggles <= 41, 1'b1)
         `CHK(relay_o, relay_normal)
         run_cycles = 0;
         toggles = 0;
      end
   end
   task automatic probe(input logic en, input int len);
      int seen;
      seen = 0;
      enable = en;
      magnet = 1'b1;
      repeat (len + HOLD + 5) begin
         @(negedge clock_i);
         if (learning_o !== 1'b0) seen++;
         if (--len == 0) magnet = 1'b0;
      end
      `CHK(seen, 0)
   endtask : probe
   task automatic learn_run(input logic [15:0] a, b, input logic nrm);
      int n;
      n = 0;
      enable = 1'b1;
      lvl_a = a;
      lvl_b = b;
      relay_normal = nrm;
      exp_q.push_back(learned(a, b));
      magnet = 1'b1;
      @(negedge clock_i);
      while (learning_o !== 1'b1 && n < 100) begin
         n++;
         @(negedge clock_i);
      end
      `CHK(n >= HOLD - 1 && n <= HOLD + 1, 1'b1)
      repeat (100) @(negedge clock_i);
      magnet = 1'b0;
      n = 0;
      while (learning_o === 1'b1 && n < 3000) begin
         n++;
         @(negedge clock_i);
      end
      if (n == 3000) begin
         n_errors++;
      end
      repeat (20) @(negedge clock_i);
      `CHK(threshold_o, learned(a, b))
   endtask : learn_run
   initial begin
      void'($urandom(41399));
      repeat (5) @(negedge clock_i);
      rst_n_i = 1'b1;
      @(negedge clock_i);
      `CHK(threshold_o, 16'h0064)
      probe(1'b0, 60);
      probe(1'b1, HOLD - 2);
      learn_run(16'h0030, 16'h0050, 1'b0);
      learn_run(16'h0300, 16'h0200, 1'b1);
      learn_run(16'h0004, 16'h0007, 1'b0);
      repeat (2) begin
         learn_run(16'h0010 + 16'($urandom % 224),
            16'h0010 + 16'($urandom % 224), 1'($urandom % 2));
      end
      `CHK(exp_q.size(), 0)
      conclude();
   end
endmodule : threshold_learning_tb
